// ===== common/fbp_pkg.sv
// Constants and types for the flash block protection gate
package fbp_pkg;
    // Array geometry: 256 KB of 32-bit words
    localparam int unsigned FLASH_BYTES = 262144;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned WORD_ADDR_W = 16;
    localparam int unsigned WORD_LSB = 2;
    localparam int unsigned DATA_W = 32;
    // Erase block of 1 KB, protection region of 2 KB
    localparam int unsigned BLOCK_BYTES = 1024;
    localparam int unsigned BLOCK_LSB = 10;
    localparam int unsigned BLOCK_W = 8;
    localparam int unsigned BLOCK_COUNT = 256;
    localparam int unsigned WORDS_PER_BLOCK = 256;
    localparam int unsigned OFFS_W = 8;
    localparam int unsigned REGION_LSB = 11;
    localparam int unsigned REGION_W = 7;
    localparam int unsigned REGION_COUNT = 128;
    // Value of every erased bit
    localparam logic [31:0] ERASED_WORD = 32'hffffffff;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [7:0] OFFS_LAST = 8'hff;
    localparam logic [7:0] OFFS_ZERO = 8'h00;
    // Sequencer states
    typedef enum logic [1:0] {
        FBP_IDLE,
        FBP_ERASE
    } fbp_seq_type;
endpackage

// ===== rtl/fbp_attr.sv
// Per-region protection attribute store
`timescale 1ns/10ps
`default_nettype none
module fbp_attr (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic set_en,
    input wire logic [fbp_pkg::REGION_W-1:0] set_region,
    input wire logic set_ro,
    input wire logic set_xo,
    input wire logic [fbp_pkg::REGION_W-1:0] look_region,
    output logic look_ro,
    output logic look_xo
);
    typedef struct packed {
        logic [fbp_pkg::REGION_COUNT-1:0] ro;
        logic [fbp_pkg::REGION_COUNT-1:0] xo;
    } fbp_attr_state_type;

    fbp_attr_state_type st;
    fbp_attr_state_type next_st;

    // One setting per 2 KB region, each written independently
    always_comb begin
        next_st = st;
        if (set_en) begin
            next_st.ro[set_region] = set_ro;
            next_st.xo[set_region] = set_xo;
        end
    end

    // Unprotected after reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Lookup is combinational so reads stay single cycle
    assign look_ro = st.ro[look_region];
    assign look_xo = st.xo[look_region];
endmodule
`default_nettype wire

// ===== rtl/fbp_gate.sv
// Flash array with access gate, erase sequencer and protection checks
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - The array holds 256 KB in 1 KB blocks, each erasable alone.
// - A finished erase leaves every bit of the block at one.
// - Each pair of adjacent blocks shares one settable protection setting.
// - A region can be marked read-only or execute-only.
// - Erase and program are refused in a read-only region.
// - Erase and program are refused in an execute-only region.
// - Execute-only regions serve instruction fetches only, not data reads.
// - Permitted reads answer in one clock cycle with no wait states.
module fbp_gate (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ifetch_req,
    input wire logic [fbp_pkg::ADDR_W-1:0] ifetch_addr,
    output logic [fbp_pkg::DATA_W-1:0] ifetch_rdata,
    output logic ifetch_valid,
    output logic ifetch_fault,
    input wire logic data_req,
    input wire logic data_dbg,
    input wire logic [fbp_pkg::ADDR_W-1:0] data_addr,
    output logic [fbp_pkg::DATA_W-1:0] data_rdata,
    output logic data_valid,
    output logic data_fault,
    input wire logic prog_req,
    input wire logic [fbp_pkg::ADDR_W-1:0] prog_addr,
    input wire logic [fbp_pkg::DATA_W-1:0] prog_wdata,
    input wire logic erase_req,
    input wire logic [fbp_pkg::ADDR_W-1:0] erase_addr,
    input wire logic attr_set,
    input wire logic [fbp_pkg::REGION_W-1:0] attr_region,
    input wire logic attr_ro,
    input wire logic attr_xo,
    output logic busy,
    output logic op_done,
    output logic op_fault
);
    typedef struct packed {
        fbp_pkg::fbp_seq_type seq;
        logic [fbp_pkg::BLOCK_W-1:0] er_blk;
        logic [fbp_pkg::OFFS_W-1:0] er_offs;
        logic [fbp_pkg::DATA_W-1:0] if_rdata;
        logic if_valid;
        logic if_fault;
        logic [fbp_pkg::DATA_W-1:0] d_rdata;
        logic d_valid;
        logic d_fault;
        logic busy;
        logic done;
        logic fault;
    } fbp_state_type;

    fbp_state_type st;
    fbp_state_type next_st;

    // Flash cells, kept apart from the reset struct
    logic [fbp_pkg::DATA_W-1:0] mem [fbp_pkg::FLASH_BYTES/fbp_pkg::WORD_BYTES];
    logic mem_we;
    logic [fbp_pkg::WORD_ADDR_W-1:0] mem_wa;
    logic [fbp_pkg::DATA_W-1:0] mem_wd;

    // Only the data and write paths consult the attribute store
    logic d_xo;
    logic w_ro;
    logic w_xo;
    logic d_block;
    logic w_block;
    logic [fbp_pkg::ADDR_W-1:0] w_addr;

    // Region index from the address bits above the 2 KB boundary
    function automatic logic [fbp_pkg::REGION_W-1:0] region_of(
        input logic [fbp_pkg::ADDR_W-1:0] a
    );
        region_of = a[fbp_pkg::ADDR_W-1:fbp_pkg::REGION_LSB];
    endfunction

    function automatic logic [fbp_pkg::WORD_ADDR_W-1:0] word_of(
        input logic [fbp_pkg::ADDR_W-1:0] a
    );
        word_of = a[fbp_pkg::ADDR_W-1:fbp_pkg::WORD_LSB];
    endfunction

    // Either protection kind locks the region against program and erase
    function automatic logic write_refused(
        input logic ro,
        input logic xo
    );
        write_refused = ro || xo;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Attribute lookups for the data and write address paths. Fetches may
    // read every region, so that path needs no copy of the store; each copy
    // costs 256 flops, which buys a lookup with no shared-port arbitration.
    fbp_attr u_attr_d (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_en(attr_set),
        .set_region(attr_region),
        .set_ro(attr_ro),
        .set_xo(attr_xo),
        .look_region(region_of(data_addr)),
        .look_ro(),
        .look_xo(d_xo)
    );
    // Write path looks at erase address first, else program address
    assign w_addr = erase_req ? erase_addr : prog_addr;
    fbp_attr u_attr_w (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_en(attr_set),
        .set_region(attr_region),
        .set_ro(attr_ro),
        .set_xo(attr_xo),
        .look_region(region_of(w_addr)),
        .look_ro(w_ro),
        .look_xo(w_xo)
    );

    // Refusal decisions, shared by the read path and the sequencer
    assign d_block = data_req && d_xo;
    assign w_block = write_refused(w_ro, w_xo);

    ////////////////////////////////////////////////////////////////////
    // Next state: reads, write gating and erase walk
    always_comb begin
        next_st = st;
        mem_we = 1'b0;
        mem_wa = word_of(prog_addr);
        mem_wd = prog_wdata;
        next_st.done = 1'b0;
        next_st.fault = 1'b0;
        // Fetch path may read any region
        next_st.if_valid = ifetch_req;
        next_st.if_fault = 1'b0;
        next_st.if_rdata = ifetch_req ? mem[word_of(ifetch_addr)]
                                      : fbp_pkg::ZERO_WORD;
        // Data and debug reads are blocked in execute-only regions; a
        // debugger read comes on this same path with data_dbg set, and
        // gets no wider view than the processor's own data reads
        if (d_block) begin
            next_st.d_valid = 1'b0;
            next_st.d_fault = 1'b1;
            next_st.d_rdata = fbp_pkg::ZERO_WORD;
        end else begin
            next_st.d_valid = data_req;
            next_st.d_fault = 1'b0;
            next_st.d_rdata = data_req ? mem[word_of(data_addr)]
                                       : fbp_pkg::ZERO_WORD;
        end
        // Idle takes one program or erase per cycle. An erase then owns
        // the write port for 256 cycles; requests seen meanwhile are
        // dropped, so the requester must wait for busy to fall.
        case (st.seq)
            fbp_pkg::FBP_IDLE: begin
                if (erase_req) begin
                    if (w_block) begin
                        next_st.fault = 1'b1;
                        next_st.done = 1'b1;
                    end else begin
                        // Only the addressed block is touched
                        next_st.er_blk =
                            erase_addr[fbp_pkg::ADDR_W-1:fbp_pkg::BLOCK_LSB];
                        next_st.er_offs = fbp_pkg::OFFS_ZERO;
                        next_st.seq = fbp_pkg::FBP_ERASE;
                        next_st.busy = 1'b1;
                    end
                end else if (prog_req) begin
                    if (w_block) begin
                        next_st.fault = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                    end
                    next_st.done = 1'b1;
                end
            end
            fbp_pkg::FBP_ERASE: begin
                // One word per cycle; requests are dropped while busy
                mem_we = 1'b1;
                mem_wa = {st.er_blk, st.er_offs};
                mem_wd = fbp_pkg::ERASED_WORD;
                next_st.er_offs = st.er_offs + 8'h01;
                if (st.er_offs == fbp_pkg::OFFS_LAST) begin
                    next_st.seq = fbp_pkg::FBP_IDLE;
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                end
            end
            default: begin
                next_st.seq = fbp_pkg::FBP_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Array write port, no reset on cell contents
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Outputs come straight from the state flops, no logic after them
    assign ifetch_rdata = st.if_rdata;
    assign ifetch_valid = st.if_valid;
    assign ifetch_fault = st.if_fault;
    assign data_rdata = st.d_rdata;
    assign data_valid = st.d_valid;
    assign data_fault = st.d_fault;
    assign busy = st.busy;
    assign op_done = st.done;
    assign op_fault = st.fault;
endmodule
`default_nettype wire

// ===== testbench/fbp_gate_props.sv
// Port checker for the flash protection gate
`timescale 1ns/10ps
`default_nettype none
module fbp_gate_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ifetch_req,
    input wire logic ifetch_valid,
    input wire logic ifetch_fault,
    input wire logic data_req,
    input wire logic [fbp_pkg::DATA_W-1:0] data_rdata,
    input wire logic data_valid,
    input wire logic data_fault,
    input wire logic prog_req,
    input wire logic erase_req,
    input wire logic busy,
    input wire logic op_done,
    input wire logic op_fault
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Every read is answered in exactly the next cycle
    property p_rd; data_req |=> data_valid ^ data_fault; endproperty
    a_rd: assert property (p_rd) else $error("read late");
    property p_fe; ifetch_req |=> ifetch_valid && !ifetch_fault; endproperty
    a_fe: assert property (p_fe) else $error("fetch refused");
    property p_no; !data_req |=> !data_valid && !data_fault; endproperty
    a_no: assert property (p_no) else $error("stray answer");
    property p_fz; data_fault |-> data_rdata == 32'h00000000; endproperty
    a_fz: assert property (p_fz) else $error("refused data shown");
    property p_of; op_fault |-> op_done; endproperty
    a_of: assert property (p_of) else $error("fault alone");
    property p_pg; prog_req && !erase_req && !busy |=> op_done; endproperty
    a_pg: assert property (p_pg) else $error("program lost");
    // An accepted erase must walk all 256 words, never fewer
    property p_el; $rose(busy) |-> ##256 (op_done && !busy); endproperty
    a_el: assert property (p_el) else $error("erase length");
    property p_eh; $rose(busy) |-> (busy && !op_done)[*8]; endproperty
    a_eh: assert property (p_eh) else $error("erase cut short");
    cover property (data_fault);
    cover property (op_fault);
    cover property ($fell(busy));
endmodule
bind fbp_gate fbp_gate_props u_props (.core_clk, .sys_rst, .ifetch_req,
    .ifetch_valid, .ifetch_fault, .data_req, .data_rdata, .data_valid,
    .data_fault, .prog_req, .erase_req, .busy, .op_done, .op_fault);
`default_nettype wire

// ===== testbench/fbp_gate_tb_top.sv
// Bench for the flash protection gate
`timescale 1ns/10ps
`default_nettype none
module fbp_gate_tb_top;
    logic core_clk = 1'b0, sys_rst = 1'b1, prog_req = 1'b0;
    logic erase_req = 1'b0, attr_set = 1'b0, attr_ro = 1'b0, attr_xo = 1'b0;
    logic ifetch_req, data_req, data_dbg, ifetch_valid, data_valid, busy;
    logic op_done, op_fault, f, ok, ifetch_fault, data_fault;
    logic [6:0] attr_region = 7'h00;
    logic [17:0] op_addr = 18'h00000, rd_addr;
    logic [31:0] op_wdata = 32'h00000000, ifetch_rdata, data_rdata, d;
    int n_mismatch = 0, checks_done = 0, cyc = 0, n;
    fbp_gate DUT (.core_clk, .sys_rst, .ifetch_req, .ifetch_addr(rd_addr),
        .ifetch_rdata, .ifetch_valid, .ifetch_fault, .data_req, .data_dbg,
        .data_addr(rd_addr), .data_rdata, .data_valid, .data_fault,
        .prog_req, .prog_addr(op_addr), .prog_wdata(op_wdata), .erase_req,
        .erase_addr(op_addr), .attr_set, .attr_region, .attr_ro, .attr_xo,
        .busy, .op_done, .op_fault);
    fbp_host HOST (.core_clk, .ifetch_req, .data_req, .data_dbg, .rd_addr,
        .ifetch_rdata, .ifetch_valid, .data_rdata, .data_valid);
    initial forever #2 core_clk = ~core_clk;
    task automatic end_sim;
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // Program or erase; n counts cycles up to the done pulse
    task automatic op(input logic er, input logic [17:0] a,
            input logic [31:0] w);
        @(posedge core_clk);
        erase_req <= er;
        prog_req <= !er;
        op_addr <= a;
        op_wdata <= w;
        for (n = 1; n < 300; n++) begin
            @(posedge core_clk);
            erase_req <= 1'b0;
            prog_req <= 1'b0;
            #1;
            if (op_done === 1'b1) break;
        end
        f = op_fault;
    endtask
    task automatic attr(input logic [6:0] r, input logic ro, xo);
        @(posedge core_clk);
        attr_set <= 1'b1;
        attr_region <= r;
        attr_ro <= ro;
        attr_xo <= xo;
        @(posedge core_clk);
        attr_set <= 1'b0;
    endtask
    // Erase wipes its block up to the last word, neighbour untouched
    task automatic t_erase;
        op(1'b0, 18'h003fc, 32'h12345678);
        op(1'b0, 18'h007fc, 32'h00000000);
        op(1'b1, 18'h00400, 32'h00000000);
        chk("erase cycles", 32'h00000101, n);
        chk("busy after erase", 32'h0, busy);
        HOST.rd(2'h1, 18'h007fc, d, ok);
        chk("erased word", fbp_pkg::ERASED_WORD, d);
        HOST.rd(2'h1, 18'h003fc, d, ok);
        chk("kept word", 32'h12345678, d);
        chk("read fault", 32'h0, data_fault);
        chk("read valid", 32'h1, ok);
    endtask
    // Read-only pair: both blocks refuse, next region still writable
    task automatic t_ro;
        op(1'b0, 18'h00ffc, 32'h5a5a0f0f);
        attr(7'h01, 1'b1, 1'b0);
        op(1'b0, 18'h00ffc, 32'h00000000);
        chk("ro program fault", 32'h1, f);
        op(1'b1, 18'h00800, 32'h00000000);
        chk("ro erase fault", 32'h1, f);
        HOST.rd(2'h1, 18'h00ffc, d, ok);
        chk("ro word", 32'h5a5a0f0f, d);
        op(1'b0, 18'h01000, 32'h00000000);
        chk("next region fault", 32'h0, f);
    endtask
    // Execute-only: fetch served, data and debugger reads refused
    task automatic t_xo;
        op(1'b0, 18'h01804, 32'hc0de0001);
        attr(7'h03, 1'b0, 1'b1);
        HOST.rd(2'h0, 18'h01804, d, ok);
        chk("xo fetch", 32'hc0de0001, d);
        chk("xo fetch valid", 32'h1, ok);
        chk("xo fetch fault", 32'h0, ifetch_fault);
        for (int k = 1; k < 3; k++) begin
            HOST.rd(k[1:0], 18'h01804, d, ok);
            chk("xo read data", 32'h0, d);
            chk("xo read valid", 32'h0, ok);
            chk("xo read fault", 32'h1, data_fault);
        end
        op(1'b1, 18'h01c00, 32'h00000000);
        chk("xo erase fault", 32'h1, f);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_erase;
        t_ro;
        t_xo;
        end_sim;
    end
    // Hang guard, well above one erase walk and the reads
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            end_sim;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/fbp_host.sv
// Fetch, data and debugger reader facing the gate
`timescale 1ns/10ps
`default_nettype none
module fbp_host (
    input wire logic core_clk,
    output logic ifetch_req = 1'b0,
    output logic data_req = 1'b0,
    output logic data_dbg = 1'b0,
    output logic [17:0] rd_addr = 18'h00000,
    input wire logic [31:0] ifetch_rdata,
    input wire logic ifetch_valid,
    input wire logic [31:0] data_rdata,
    input wire logic data_valid
);
    // k: 0 fetch, 1 data, 2 debugger; idle address inverted, never stale
    task automatic rd(input logic [1:0] k, input logic [17:0] a,
            output logic [31:0] d, output logic ok);
        @(posedge core_clk);
        ifetch_req <= k == 2'h0;
        data_req <= k != 2'h0;
        data_dbg <= k == 2'h2;
        rd_addr <= a;
        @(posedge core_clk);
        ifetch_req <= 1'b0;
        data_req <= 1'b0;
        rd_addr <= ~a;
        #1;
        d = k == 2'h0 ? ifetch_rdata : data_rdata;
        ok = k == 2'h0 ? ifetch_valid : data_valid;
    endtask
endmodule
`default_nettype wire
